// file: fnd_regs.vh
// Constants of the fractional-N divider core: register map, fields, reset values, ratios.
// Assumes byte addresses on a 32-bit APB with each register in one aligned word.
// Function
// (R1) Reference divider divides by 256, 280, 288 or 384 from two select bits.
// (R2) Quarter-step interpolation makes effective reference ratios 1024, 1120, 1152, 1536.
// (R3) Comparison rate equals four times the channel raster.
// (R4) Main divider holds a programmable 13-bit integer ratio N.
// (R5) Each main cycle divides by N or N+1; average is N plus k quarters.
// (R6) Effective main ratio is 15 bits, four times N plus k, loaded by software.
// (R7) Software programs effective main ratio only between 2048 and 32767.
// (R8) Test bit routes reference divider output onto switching output C.
// (R9) Test bit routes main divider output onto switching output F.
// (R10) Both dividers stay reset until a complete main ratio has been written.
// (R11) A new divider setting applies only after its bus transfer completes.
// (R12) A new setting never applies while the pump output sources or sinks.
// (R13) Select 00 gives 1120, a gives 1152, b gives 1024, both give 1536.
// (R14) Controller sends main ratio top, middle, low parts with reference select bits.
// (R15) Divider parts follow in order within one transfer or the transfer ends.
// (R16) N is the upper thirteen ratio bits, k the two lowest.
// (R17) Over four cycles N+1 is used exactly k times, evenly spread.
`ifndef FND_REGS_VH
`define FND_REGS_VH

`define FND_ADDR_DIV        8'h00
`define FND_ADDR_CTRL       8'h04
`define FND_ADDR_STATUS     8'h08

`define FND_DIV_RATIO_LSB   0
`define FND_DIV_RATIO_MSB   14
`define FND_DIV_SEL_A_BIT   16
`define FND_DIV_SEL_B_BIT   17

`define FND_CTRL_TEST_BIT   0
`define FND_CTRL_SW_C_BIT   1
`define FND_CTRL_SW_F_BIT   2

`define FND_STAT_RUN_BIT    0
`define FND_STAT_PEND_BIT   1
`define FND_STAT_ACC_LSB    2
`define FND_STAT_ACC_MSB    3

`define FND_RATIO_RST       15'h0800
`define FND_CTRL_RST        3'h0

`define FND_REF_SEL_NONE    9'h118
`define FND_REF_SEL_A       9'h120
`define FND_REF_SEL_B       9'h100
`define FND_REF_SEL_AB      9'h180

`endif

// file: div_counter.v
// Programmable edge counter: emits one tick per ratio input edges.
// Assumes edge_i is a one-cycle pulse already in the clock_i domain.
`timescale 1ns/100ps
`default_nettype none
module div_counter #(
  parameter W = 14
) (
  input  wire         clock_i,
  input  wire         sys_rst_i,
  input  wire         hold_i,
  input  wire         edge_i,
  input  wire [W-1:0] ratio_i,
  output reg          tick_o,
  output reg          square_o
);
  reg [W-1:0] count_q;
  // A count already past a newly shortened ratio ends the period on the next input edge
  // instead of running round the whole counter range.
  wire        last_w = (count_q >= ratio_i - {{(W-1){1'b0}}, 1'b1});

  always @(posedge clock_i) begin
    if (sys_rst_i || hold_i) begin
      count_q  <= {W{1'b0}};
      tick_o   <= 1'b0;
      square_o <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      if (edge_i) begin
        if (last_w) begin
          count_q  <= {W{1'b0}};
          tick_o   <= 1'b1;
          square_o <= ~square_o;
        end else begin
          count_q <= count_q + {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: frac_n_core.v
// Fractional-N divider core: reference and main dividers with an APB register port.
// Assumes ref_osc_i and rf_in_i are asynchronous pins far slower than clock_i,
// and pump_active_i comes from the phase detector on the clock_i domain.
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "fnd_regs.vh"
module frac_n_core (
  input  wire        clock_i,
  input  wire        sys_rst_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [7:0]  paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  input  wire        ref_osc_i,
  input  wire        rf_in_i,
  input  wire        pump_active_i,
  output reg         ref_cmp_o,
  output reg         main_cmp_o,
  output reg         switch_out_c_o,
  output reg         switch_out_f_o,
  output reg         running_o
);
  // Pin synchronisers; stage one feeds stage two only.
  reg ref_s1_q;
  reg ref_s2_q;
  reg ref_s3_q;
  reg rf_s1_q;
  reg rf_s2_q;
  reg rf_s3_q;

  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      ref_s1_q <= 1'b0;
      ref_s2_q <= 1'b0;
      ref_s3_q <= 1'b0;
      rf_s1_q  <= 1'b0;
      rf_s2_q  <= 1'b0;
      rf_s3_q  <= 1'b0;
    end else begin
      ref_s1_q <= ref_osc_i;
      ref_s2_q <= ref_s1_q;
      ref_s3_q <= ref_s2_q;
      rf_s1_q  <= rf_in_i;
      rf_s2_q  <= rf_s1_q;
      rf_s3_q  <= rf_s2_q;
    end
  end

  wire ref_edge_w = ref_s2_q & ~ref_s3_q;
  wire rf_edge_w  = rf_s2_q & ~rf_s3_q;

  // Software-side staging and the settings that the dividers really use.
  reg [14:0] stage_ratio_q;
  reg        stage_sel_a_q;
  reg        stage_sel_b_q;
  reg [14:0] act_ratio_q;
  reg        act_sel_a_q;
  reg        act_sel_b_q;
  reg        pending_q;
  reg        running_q;
  reg        test_q;
  reg        sw_c_q;
  reg        sw_f_q;
  reg [1:0]  acc_q;

  wire access_w  = psel_i & penable_i & ~pready_o;
  wire wr_w      = access_w & pwrite_i;
  wire hit_div_w = (paddr_i == `FND_ADDR_DIV);
  wire hit_ctl_w = (paddr_i == `FND_ADDR_CTRL);
  wire hit_st_w  = (paddr_i == `FND_ADDR_STATUS);
  wire mapped_w  = hit_div_w | hit_ctl_w | hit_st_w;
  wire div_wr_w  = wr_w & hit_div_w;

  // A ratio write is staged at its first access edge, while pready_o is still low,
  // and handed to the dividers no earlier than the following edge, where the access completes.
  wire apply_w = pending_q & ~pump_active_i; // R11 R12

  // APB slave: one wait state, so every access ends on its second access edge.
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0;
    end else begin
      pready_o  <= access_w;
      pslverr_o <= access_w & ~mapped_w;
      prdata_o  <= 32'h0;
      if (access_w && !pwrite_i) begin
        if (hit_div_w) begin
          prdata_o[`FND_DIV_RATIO_MSB:`FND_DIV_RATIO_LSB] <= stage_ratio_q;
          prdata_o[`FND_DIV_SEL_A_BIT] <= stage_sel_a_q;
          prdata_o[`FND_DIV_SEL_B_BIT] <= stage_sel_b_q;
        end else if (hit_ctl_w) begin
          prdata_o[`FND_CTRL_TEST_BIT] <= test_q;
          prdata_o[`FND_CTRL_SW_C_BIT] <= sw_c_q;
          prdata_o[`FND_CTRL_SW_F_BIT] <= sw_f_q;
        end else if (hit_st_w) begin
          prdata_o[`FND_STAT_RUN_BIT]  <= running_q;
          prdata_o[`FND_STAT_PEND_BIT] <= pending_q;
          prdata_o[`FND_STAT_ACC_MSB:`FND_STAT_ACC_LSB] <= acc_q;
        end
      end
    end
  end

  // Register writes and the hand-over of a staged ratio.
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      stage_ratio_q <= `FND_RATIO_RST;
      stage_sel_a_q <= 1'b0;
      stage_sel_b_q <= 1'b0;
      test_q        <= 1'b0;
      sw_c_q        <= 1'b0;
      sw_f_q        <= 1'b0;
      pending_q     <= 1'b0;
    end else begin
      if (div_wr_w) begin
        stage_ratio_q <= pwdata_i[`FND_DIV_RATIO_MSB:`FND_DIV_RATIO_LSB]; // R6 R14
        stage_sel_a_q <= pwdata_i[`FND_DIV_SEL_A_BIT];
        stage_sel_b_q <= pwdata_i[`FND_DIV_SEL_B_BIT];
      end
      if (wr_w && hit_ctl_w) begin
        test_q <= pwdata_i[`FND_CTRL_TEST_BIT];
        sw_c_q <= pwdata_i[`FND_CTRL_SW_C_BIT];
        sw_f_q <= pwdata_i[`FND_CTRL_SW_F_BIT];
      end
      // A new write in the cycle of a hand-over keeps the request pending.
      if (div_wr_w)
        pending_q <= 1'b1; // R11
      else if (apply_w)
        pending_q <= 1'b0;
    end
  end

  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      act_ratio_q <= `FND_RATIO_RST;
      act_sel_a_q <= 1'b0;
      act_sel_b_q <= 1'b0;
      running_q   <= 1'b0;
    end else if (apply_w) begin
      act_ratio_q <= stage_ratio_q; // R12
      act_sel_a_q <= stage_sel_a_q;
      act_sel_b_q <= stage_sel_b_q;
      running_q   <= 1'b1; // R10
    end
  end

  // Reference ratio from the two select bits; four times each gives the
  // effective ratio once the main divider interpolates in quarter steps.
  reg [8:0] ref_ratio_w;
  always @* begin
    case ({act_sel_b_q, act_sel_a_q}) // R1 R2 R13
      2'b00:   ref_ratio_w = `FND_REF_SEL_NONE;
      2'b01:   ref_ratio_w = `FND_REF_SEL_A;
      2'b10:   ref_ratio_w = `FND_REF_SEL_B;
      2'b11:   ref_ratio_w = `FND_REF_SEL_AB;
      default: ref_ratio_w = `FND_REF_SEL_NONE;
    endcase
  end

  // Fractional sequencer: a two-bit accumulator adds k each main cycle and
  // its carry selects N+1, giving exactly k carries in any four cycles.
  wire [12:0] n_w     = act_ratio_q[14:2]; // R4 R16
  wire [1:0]  k_w     = act_ratio_q[1:0];  // R16
  wire [2:0]  acc_sum = {1'b0, acc_q} + {1'b0, k_w};
  wire        carry_w = acc_sum[2]; // R5 R17
  wire [13:0] main_ratio_w = {1'b0, n_w} + {13'h0, carry_w}; // R5

  wire ref_tick_w;
  wire ref_sq_w;
  wire main_tick_w;
  wire main_sq_w;

  always @(posedge clock_i) begin
    if (sys_rst_i || !running_q)
      acc_q <= 2'h0;
    else if (main_tick_w)
      acc_q <= acc_sum[1:0]; // R17
  end

  div_counter #(.W(9)) ref_div (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .hold_i    (~running_q),
    .edge_i    (ref_edge_w),
    .ratio_i   (ref_ratio_w),
    .tick_o    (ref_tick_w),
    .square_o  (ref_sq_w)
  ); // R1 R3 R10

  div_counter #(.W(14)) main_div (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .hold_i    (~running_q),
    .edge_i    (rf_edge_w),
    .ratio_i   (main_ratio_w),
    .tick_o    (main_tick_w),
    .square_o  (main_sq_w)
  ); // R4 R10

  // Outputs, each from a flip-flop.
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      ref_cmp_o      <= 1'b0;
      main_cmp_o     <= 1'b0;
      switch_out_c_o <= 1'b0;
      switch_out_f_o <= 1'b0;
      running_o      <= 1'b0;
    end else begin
      ref_cmp_o      <= ref_tick_w; // R3
      main_cmp_o     <= main_tick_w;
      switch_out_c_o <= test_q ? ref_sq_w : sw_c_q;  // R8
      switch_out_f_o <= test_q ? main_sq_w : sw_f_q; // R9
      running_o      <= running_q;
    end
  end
endmodule
`default_nettype wire

// file: fnd_checker_assertions.sv
// Concurrent checks on the ports of the fractional-N divider core.
// Assumes it is bound to frac_n_core and sees one aligned APB word per register.
`timescale 1ns/100ps
`default_nettype none
module fnd_checker (
  input wire logic        clock_i,
  input wire logic        sys_rst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        pump_active_i,
  input wire logic        ref_cmp_o,
  input wire logic        main_cmp_o,
  input wire logic        switch_out_c_o,
  input wire logic        switch_out_f_o,
  input wire logic        running_o
);
  logic [2:0] ctrl_q;
  logic       div_seen_q;
  wire        done = psel_i && penable_i && pready_o && pwrite_i;
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  // Shadow of completed writes, used to predict the switching outputs and the run flag.
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      ctrl_q     <= 3'h0;
      div_seen_q <= 1'b0;
    end else begin
      if (done && paddr_i == 8'h04) ctrl_q <= pwdata_i[2:0];
      if (done && paddr_i == 8'h00) div_seen_q <= 1'b1;
    end
  end
  a_ready_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("pready late");
  a_ready_pulse: assert property (pready_o |=> !pready_o) else $error("pready too long");
  a_err_unmapped: assert property (pready_o && paddr_i > 8'h08 |-> pslverr_o && prdata_o == 32'h0)
    else $error("unmapped access not refused");
  a_hold_reset: assert property (!div_seen_q |-> !running_o) else $error("early run");
  a_no_pulse_held: assert property (!running_o |-> !ref_cmp_o && !main_cmp_o)
    else $error("pulse while held");
  a_apply_quiet: assert property ($rose(running_o) |-> !$past(pump_active_i, 2))
    else $error("applied while pumping");
  a_swc_normal: assert property (!ctrl_q[0] && $stable(ctrl_q) |-> switch_out_c_o == ctrl_q[1])
    else $error("switch c wrong");
  a_swf_normal: assert property (!ctrl_q[0] && $stable(ctrl_q) |-> switch_out_f_o == ctrl_q[2])
    else $error("switch f wrong");
endmodule
`default_nettype wire

// file: fnd_pins_model.sv
// Free-running reference oscillator and VCO seen at the divider pins.
// Assumes both periods stay well above four system clock periods.
`timescale 1ns/100ps
`default_nettype none
module fnd_pins_model #(
  parameter int REF_HALF = 400,
  parameter int RF_HALF  = 350
) (
  output var logic ref_osc_o,
  output var logic rf_o
);
  initial begin
    ref_osc_o = 1'b0;
    forever #(REF_HALF) ref_osc_o = ~ref_osc_o;
  end
  // The offset keeps VCO edges away from system clock edges.
  initial begin
    rf_o = 1'b0;
    #137;
    forever #(RF_HALF) rf_o = ~rf_o;
  end
endmodule
`default_nettype wire

// file: fractional_n_divider_core_tb.sv
// Self-checking bench: APB master, random pump activity, pin model, ratio counting.
// Assumes the core answers every APB access after one wait state.
`timescale 1ns/100ps
`default_nettype none
module fractional_n_divider_core_tb;
  logic        clock_i = 1'b0, sys_rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0;
  logic        pwrite_i = 1'b0, pump_active_i = 1'b0, hold_pump = 1'b0, rd_err;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic        pready_o, pslverr_o, ref_osc_i, rf_in_i, ref_cmp_o, main_cmp_o;
  logic        switch_out_c_o, switch_out_f_o, running_o;
  int          n_fail = 0, n_checks = 0, rc = 0, fc = 0, cc = 0, ffc = 0;
  frac_n_core i_dut (.*);
  fnd_pins_model i_pins (.ref_osc_o(ref_osc_i), .rf_o(rf_in_i));
  initial forever #50 clock_i = ~clock_i;
  always @(posedge clock_i) pump_active_i <= hold_pump || ($urandom % 4 == 0);
  always @(posedge ref_osc_i) rc++;
  always @(posedge rf_in_i) fc++;
  always @(posedge switch_out_c_o) cc++;
  always @(posedge switch_out_f_o) ffc++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    do @(posedge clock_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    rd_err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  function automatic int ref_ratio(input int s);
    return (s == 0) ? 280 : (s == 1) ? 288 : (s == 2) ? 256 : 384;
  endfunction
  task summarize;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    int n, k, p, q, x, s, c0, f0;
    void'($urandom(32'h2393ff82));
    repeat (12) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    apb(1'b1, 8'h04, 32'h6);
    repeat (3) @(posedge clock_i);
    chk({switch_out_c_o, switch_out_f_o}, 2'b11);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd[0], 1'b0);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd_err, 1'b1);
    chk(rd, 32'h0);
    hold_pump <= 1'b1;
    apb(1'b1, 8'h00, 32'h0800);
    repeat (20) @(posedge clock_i);
    chk(running_o, 1'b0);
    hold_pump <= 1'b0;
    repeat (20) @(posedge clock_i);
    chk(running_o, 1'b1);
    for (int i = 0; i < 4; i++) begin
      n = 512 + $urandom % 8;
      k = $urandom % 4;
      if (i == 3) apb(1'b1, 8'h04, 32'h1);
      c0 = cc;
      f0 = ffc;
      apb(1'b1, 8'h00, (i << 16) | (4 * n + k));
      fork
        begin
          repeat (2) @(posedge clock_i iff ref_cmp_o);
          p = rc;
          @(posedge clock_i iff ref_cmp_o);
          chk(rc - p, ref_ratio(i));
        end
        begin
          repeat (2) @(posedge clock_i iff main_cmp_o);
          q = fc;
          s = 0;
          repeat (4) begin
            @(posedge clock_i iff main_cmp_o);
            x = fc - q;
            q = fc;
            s += x;
            chk(x == n || x == n + 1, 1'b1);
          end
          chk(s, 4 * n + k);
        end
      join
    end
    chk(cc > c0, 1'b1);
    chk(ffc > f0, 1'b1);
    summarize();
  end
  initial begin
    #(100000 * 100);
    n_fail++;
    summarize();
  end
endmodule
bind frac_n_core fnd_checker i_chk (.*);
`default_nettype wire
